// File: pkg/nand_host_defs.svh
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH
`define CMD_READ 8'h00
`define CMD_READ_CONF 8'h30
`define CMD_COPY_CONF 8'h35
`define CMD_BOOST_CONF 8'h36
`define CMD_CACHE_SEQ 8'h31
`define CMD_CACHE_END 8'h3F
`define CMD_PLANE_READ 8'h32
`define CMD_COL_CHANGE 8'h05
`define CMD_ROW_CHANGE 8'h06
`define CMD_CHANGE_CONF 8'hE0
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78
`define CMD_RESET 8'hFF
`define CMD_RESET_LUN 8'hFA
`define CMD_PROG 8'h80
`define CMD_PROG_PLANE2 8'h81
`define CMD_PROG_CONF 8'h10
`define CMD_CACHE_CONF 8'h15
`define CMD_PLANE_NEXT 8'h11
`define CMD_RAND_IN 8'h85
`define CMD_REPROG 8'h8B
`define CMD_ERASE 8'h60
`define CMD_ERASE_CONF 8'hD0
`define CMD_ERASE_PLANE 8'hD1
`define CMD_READ_ID 8'h90
`define CMD_GET_FEAT 8'hEE
`define CLK_PERIOD_NS 8
`define SETUP_NS 10
`define STROBE_LOW_NS 15
`define STROBE_HIGH_NS 10
`define EDO_LIMIT_NS 30
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: pkg/nand_host_pkg.sv
package nand_host_pkg;
  typedef enum logic [1:0] {
    KIND_CMD = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_WDATA = 2'h2,
    KIND_RDATA = 2'h3
  } op_kind_type;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_WAIT = 5'b0_0010,
    ST_SETUP = 5'b0_0100,
    ST_LOW = 5'b0_1000,
    ST_HIGH = 5'b1_0000
  } state_type;
endpackage

// File: rtl/nand_host.sv
// Behaviour
// - read sequences 00-30/35/36, 31, 00-31, 3F
// - 05 or 06, addresses, then E0
// - during read busy only reset and status
// - program sequences 80-10, 80-15, 85, 8B-10
// - erase 60-D0; two-plane 60-60-D0, 60-D1-60-D0
// - two-plane loads separated by 11
// - two-plane read 00-32-00-30/35
// - commands and addresses on low lane only
// - command latched on input strobe rise, cle
// - address latched on input strobe rise, ale
// - write data per input strobe, protect high
// - protect high through modify command, address cycles
// - select may rise between read cycles
// - fast cycles capture on next falling edge; here every read samples as the strobe rises
// - strobes held high while device busy, except for status and reset commands
`timescale 1ns/10ps
`include "nand_host_defs.svh"
module nand_host #(
  parameter int DATA_W = 8,
  parameter int SETUP_CYC = `SETUP_CYC,
  parameter int LOW_CYC = `LOW_CYC,
  parameter int HIGH_CYC = `HIGH_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic OP_VALID_I,
  input wire nand_host_pkg::op_kind_type OP_KIND_I,
  input wire logic [DATA_W-1:0] OP_DATA_I,
  input wire logic WRITE_EN_I,
  output logic OP_READY_O,
  output logic RD_VALID_O,
  output logic [DATA_W-1:0] RD_DATA_O,
  output logic BUSY_O,
  output logic CHIP_SELECT_N_O,
  output logic CMD_LATCH_EN_O,
  output logic ADDR_LATCH_EN_O,
  output logic INPUT_STROBE_N_O,
  output logic OUTPUT_STROBE_N_O,
  output logic PROTECT_N_O,
  input wire logic BUSY_FLAG_N_I,
  input wire logic [DATA_W-1:0] IO_I,
  output logic [DATA_W-1:0] IO_O,
  output logic [DATA_W-1:0] IO_OE_O
);
  import nand_host_pkg::*;

  localparam logic [7:0] SETUP_LAST = 8'(SETUP_CYC - 1);
  localparam logic [7:0] LOW_LAST = 8'(LOW_CYC - 1);
  localparam logic [7:0] HIGH_LAST = 8'(HIGH_CYC - 1);

  state_type state_r, state_nxt;
  op_kind_type kind_r;
  logic [DATA_W-1:0] data_r;
  logic [7:0] cnt_r;
  logic busy_s1_r, busy_s2_r;
  logic [DATA_W-1:0] io_s1_r, io_s2_r;
  logic modify_r, narrow_r;
  logic ce_n_r, cle_r, ale_r, we_n_r, re_n_r, prot_r, oe_r;
  logic [DATA_W-1:0] io_o_r, rd_data_r;
  logic ready_r, rd_valid_r;
  logic last_cnt, capture;

  function automatic logic busy_ok(input op_kind_type k,
                                   input logic [7:0] c);
    busy_ok = (k == KIND_CMD) &&
              (c == `CMD_STATUS || c == `CMD_STATUS_ENH ||
               c == `CMD_RESET || c == `CMD_RESET_LUN);
  endfunction

  // pins come from another domain; only the second stage is read
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      io_s1_r <= '0;
      io_s2_r <= '0;
    end else begin
      busy_s1_r <= BUSY_FLAG_N_I;
      busy_s2_r <= busy_s1_r;
      io_s1_r <= IO_I;
      io_s2_r <= io_s1_r;
    end
  end

  always_comb begin
    case (state_r)
      ST_SETUP: last_cnt = (cnt_r == SETUP_LAST);
      ST_LOW: last_cnt = (cnt_r == LOW_LAST);
      ST_HIGH: last_cnt = (cnt_r == HIGH_LAST);
      default: last_cnt = 1'b0;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (OP_VALID_I && ready_r) begin
          // hold strobes off a busy device unless the code is allowed
          if (!busy_s2_r && !busy_ok(OP_KIND_I, OP_DATA_I[7:0])) begin
            state_nxt = ST_WAIT;
          end else begin
            state_nxt = ST_SETUP;
          end
        end
      end
      ST_WAIT: begin
        if (busy_s2_r) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (last_cnt) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (last_cnt) begin
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (last_cnt) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      kind_r <= KIND_CMD;
      data_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (state_r == ST_IDLE && OP_VALID_I && ready_r) begin
        kind_r <= OP_KIND_I;
        data_r <= OP_DATA_I;
      end
      ready_r <= (state_nxt == ST_IDLE) &&
                 !(state_r == ST_IDLE && OP_VALID_I && ready_r);
    end
  end

  // sequence stays open through its confirm strobe, so protect holds there
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      modify_r <= 1'b0;
    end else if (state_r == ST_SETUP && cnt_r == 8'h00 &&
                 kind_r == KIND_CMD) begin
      case (data_r[7:0])
        `CMD_PROG, `CMD_PROG_PLANE2, `CMD_RAND_IN, `CMD_REPROG,
        `CMD_PLANE_NEXT: modify_r <= 1'b1;
        `CMD_ERASE, `CMD_ERASE_PLANE: modify_r <= 1'b1;
        default: modify_r <= modify_r;
      endcase
    end else if (state_r == ST_HIGH && last_cnt && kind_r == KIND_CMD &&
                 data_r[7:0] inside {`CMD_PROG_CONF, `CMD_CACHE_CONF,
                 `CMD_ERASE_CONF, `CMD_RESET, `CMD_RESET_LUN}) begin
      modify_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      narrow_r <= 1'b0;
    end else if (state_r == ST_SETUP && cnt_r == 8'h00 &&
                 kind_r == KIND_CMD) begin
      case (data_r[7:0])
        `CMD_STATUS, `CMD_STATUS_ENH, `CMD_READ_ID,
        `CMD_GET_FEAT: narrow_r <= 1'b1;
        `CMD_READ, `CMD_READ_CONF, `CMD_COPY_CONF, `CMD_BOOST_CONF,
        `CMD_CACHE_SEQ, `CMD_CACHE_END, `CMD_PLANE_READ, `CMD_COL_CHANGE,
        `CMD_ROW_CHANGE, `CMD_CHANGE_CONF: begin
          narrow_r <= 1'b0;
        end
        default: narrow_r <= 1'b0;
      endcase
    end
  end

  // pin drive; select held low only for the word in flight
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ce_n_r <= 1'b1;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      oe_r <= 1'b0;
      io_o_r <= '0;
    end else begin
      ce_n_r <= !(state_nxt inside {ST_SETUP, ST_LOW, ST_HIGH});
      cle_r <= (state_nxt != ST_IDLE && state_nxt != ST_WAIT) &&
               (state_r != ST_IDLE) && kind_r == KIND_CMD;
      ale_r <= (state_nxt != ST_IDLE && state_nxt != ST_WAIT) &&
               (state_r != ST_IDLE) && kind_r == KIND_ADDR;
      we_n_r <= !(state_nxt == ST_LOW && kind_r != KIND_RDATA);
      re_n_r <= !(state_nxt == ST_LOW && kind_r == KIND_RDATA);
      oe_r <= (state_nxt inside {ST_SETUP, ST_LOW, ST_HIGH}) &&
              (state_r != ST_IDLE) && kind_r != KIND_RDATA;
      if (kind_r == KIND_WDATA) begin
        io_o_r <= data_r;
      end else begin
        io_o_r <= DATA_W'(data_r[7:0]);
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prot_r <= 1'b0;
    end else begin
      prot_r <= WRITE_EN_I || modify_r;
    end
  end

  // pin seen two stages late: this samples it as the strobe rises
  assign capture = kind_r == KIND_RDATA && last_cnt &&
                   state_r == ST_HIGH;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= capture;
      if (capture) begin
        rd_data_r <= narrow_r ? DATA_W'(io_s2_r[7:0]) : io_s2_r;
      end
    end
  end

  assign OP_READY_O = ready_r;
  assign RD_VALID_O = rd_valid_r;
  assign RD_DATA_O = rd_data_r;
  assign BUSY_O = !busy_s2_r;
  assign CHIP_SELECT_N_O = ce_n_r;
  assign CMD_LATCH_EN_O = cle_r;
  assign ADDR_LATCH_EN_O = ale_r;
  assign INPUT_STROBE_N_O = we_n_r;
  assign OUTPUT_STROBE_N_O = re_n_r;
  assign PROTECT_N_O = prot_r;
  assign IO_O = io_o_r;
  assign IO_OE_O = {DATA_W{oe_r}};

  sequence we_rise_s;
    $rose(we_n_r);
  endsequence

  strobe_idle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == ST_WAIT |-> we_n_r && re_n_r)
    else $error("strobe moved while waiting on busy");
  cmd_latch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    we_rise_s and cle_r |-> !ce_n_r && !ale_r && re_n_r)
    else $error("command latch qualifiers wrong");
  addr_latch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    we_rise_s and ale_r |-> !ce_n_r && !cle_r && re_n_r)
    else $error("address latch qualifiers wrong");
  data_in_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    we_rise_s and !cle_r && !ale_r |-> !ce_n_r && re_n_r && prot_r)
    else $error("data written without qualifiers");
  low_lane_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (cle_r || ale_r) && oe_r |-> (io_o_r >> 8) == '0)
    else $error("upper lane used for command or address");
  modify_prot_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    we_rise_s and cle_r && $past(modify_r, 4) |-> prot_r && modify_r)
    else $error("modify sequence closed before its confirm");
  read_strobe_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(re_n_r) |-> !cle_r && !ale_r && we_n_r ##1 !oe_r)
    else $error("output strobe with wrong qualifiers");
  narrow_rd_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    rd_valid_r && narrow_r |-> (rd_data_r >> 8) == '0)
    else $error("narrow read has upper bits");
  busy_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == ST_SETUP && $past(state_r) == ST_IDLE && !$past(busy_s2_r)
    |-> busy_ok(kind_r, data_r[7:0]))
    else $error("disallowed op started while busy");
endmodule

// File: test/nand_dev_model.sv
`timescale 1ns/10ps
module nand_dev_model (
  input wire logic cs_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [15:0] io_i,
  output logic [15:0] io_o,
  output logic busy_n_o
);
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [7:0] col = 8'h00;
  logic [15:0] last_addr = 16'h0000;
  logic [15:0] last_data = 16'h0000;
  logic [15:0] word_now;
  logic wp_seen = 1'b0;
  logic narrow = 1'b0;
  logic first = 1'b0;
  logic modify = 1'b0;
  int bad = 0;
  initial busy_n_o = 1'b1;
  // word only stands while selected with the strobe low; otherwise the
  // lane shows its inverse, so a sample taken too early is caught
  assign word_now = narrow ? {8'h5a, 8'he0} : {ptr ^ 8'h3c, ptr};
  assign io_o = (cs_n_i || re_n_i) ? ~word_now : word_now;
  always @(posedge re_n_i) if (!cs_n_i) ptr++;
  always @(negedge re_n_i) if (!busy_n_o) bad++;
  always @(negedge wp_n_i) if (modify) busy_n_o = 1'b1;
  always @(posedge we_n_i) begin
    if (!cs_n_i && !busy_n_o &&
        !(cle_i && io_i[7:0] inside {8'h70, 8'h78, 8'hff, 8'hfa}))
      bad++;
    if (!cs_n_i && re_n_i && cle_i && !ale_i) begin
      last_cmd = io_i[7:0];
      wp_seen = wp_n_i;
      first = 1'b1;
      narrow = io_i[7:0] inside {8'h70, 8'h78, 8'h90, 8'hee};
      if (io_i[7:0] inside {8'h30, 8'he0}) ptr = col;
      modify = io_i[7:0] inside {8'h10, 8'h15, 8'hd0};
      if (io_i[7:0] inside {8'h30, 8'h35, 8'h36, 8'h31, 8'h3f, 8'h11,
          8'h32, 8'h10, 8'h15, 8'hd0} && (wp_n_i || !modify)) begin
        busy_n_o <= 1'b0;
        busy_n_o <= #400 1'b1;
      end
    end else if (!cs_n_i && re_n_i && ale_i && !cle_i) begin
      if (first) col = io_i[7:0];
      first = 1'b0;
      last_addr = io_i;
    end else if (!cs_n_i && re_n_i && !ale_i && !cle_i && wp_n_i)
      last_data = io_i;
  end
endmodule

// File: test/nand_host_tb_top.sv
`timescale 1ns/10ps
module nand_host_tb_top;
  import nand_host_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic OP_VALID_I = 1'b0;
  logic WRITE_EN_I = 1'b0;
  op_kind_type OP_KIND_I = KIND_CMD;
  logic [15:0] OP_DATA_I = 16'h0000;
  logic [15:0] RD_DATA_O, IO_O, IO_OE_O, dev_io, pin, got, d;
  logic OP_READY_O, RD_VALID_O, BUSY_O, CHIP_SELECT_N_O, PROTECT_N_O;
  logic CMD_LATCH_EN_O, ADDR_LATCH_EN_O, INPUT_STROBE_N_O;
  logic OUTPUT_STROBE_N_O, busy_n;
  int failures = 0;
  int checks_done = 0;
  integer seed = 32'h962b_1b53;
  logic [7:0] codes [30] = '{8'h00, 8'h32, 8'h00, 8'h30, 8'h80, 8'h11,
    8'h81, 8'h15, 8'h8b, 8'h11, 8'h8b, 8'h10, 8'h85, 8'h11, 8'h85, 8'h10,
    8'h60, 8'h60, 8'hd0, 8'h60, 8'hd1, 8'h60, 8'hd0, 8'h31, 8'h3f, 8'h90,
    8'hee, 8'h78, 8'hfa, 8'hff};
  always #4 CLK_I = ~CLK_I;
  assign pin = IO_OE_O[0] ? IO_O : dev_io;
  nand_host #(.DATA_W(16)) dut (.CLK_I, .RST_I, .OP_VALID_I, .OP_KIND_I,
    .OP_DATA_I, .WRITE_EN_I, .OP_READY_O, .RD_VALID_O, .RD_DATA_O, .BUSY_O,
    .CHIP_SELECT_N_O, .CMD_LATCH_EN_O, .ADDR_LATCH_EN_O, .INPUT_STROBE_N_O,
    .OUTPUT_STROBE_N_O, .PROTECT_N_O, .BUSY_FLAG_N_I(busy_n), .IO_I(pin),
    .IO_O, .IO_OE_O);
  nand_dev_model dev (.cs_n_i(CHIP_SELECT_N_O), .cle_i(CMD_LATCH_EN_O),
    .ale_i(ADDR_LATCH_EN_O), .we_n_i(INPUT_STROBE_N_O),
    .re_n_i(OUTPUT_STROBE_N_O), .wp_n_i(PROTECT_N_O), .io_i(IO_O),
    .io_o(dev_io), .busy_n_o(busy_n));
  function automatic logic [15:0] word(input logic [7:0] p);
    return {p ^ 8'h3c, p};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // which 0 waits for ready, 1 for the device to go idle
  task automatic wait_for(input int which);
    int n;
    n = 0;
    while ((which == 0 ? OP_READY_O : !BUSY_O) !== 1'b1) begin
      @(negedge CLK_I);
      if (RD_VALID_O === 1'b1) got = RD_DATA_O;
      n++;
      if (n > 500) begin
        check("wait bound", 16'h0001, 16'h0000);
        summarize();
      end
    end
  endtask
  task automatic op(input op_kind_type k, input logic [15:0] v);
    @(negedge CLK_I);
    OP_KIND_I = k;
    OP_DATA_I = v;
    OP_VALID_I = 1'b1;
    got = 16'hxxxx;
    wait_for(0);
    @(negedge CLK_I);
    OP_VALID_I = 1'b0;
    wait_for(0);
    check("idle select", {15'h0000, CHIP_SELECT_N_O}, 16'h0001);
  endtask
  task automatic cmd(input logic [7:0] c);
    op(KIND_CMD, {8'h00, c});
    check("command", {8'h00, dev.last_cmd}, {8'h00, c});
  endtask
  task automatic addr(input logic [7:0] a);
    op(KIND_ADDR, {8'h00, a});
    check("address", dev.last_addr, {8'h00, a});
  endtask
  initial begin
    repeat (8) @(negedge CLK_I);
    RST_I = 1'b0;
    WRITE_EN_I = 1'b1;
    cmd(8'h00);
    addr(8'h02);
    addr(8'h00);
    cmd(8'h30);
    check("busy after read", {15'h0000, BUSY_O}, 16'h0001);
    wait_for(1);
    for (int i = 0; i < 4; i++) begin
      op(KIND_RDATA, 16'h0000);
      check("read word", got, word(8'(2 + i)));
    end
    for (int j = 5; j < 7; j++) begin
      cmd(8'(j));
      addr(8'(j * 4));
      addr(8'h00);
      cmd(8'he0);
      op(KIND_RDATA, 16'h0000);
      check("repositioned word", got, word(8'(j * 4)));
    end
    WRITE_EN_I = 1'b0;
    cmd(8'h80);
    check("protect in sequence", {15'h0000, dev.wp_seen}, 16'h0001);
    addr(8'($random(seed)));
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      op(KIND_WDATA, d);
      check("write word", dev.last_data, d);
    end
    cmd(8'h10);
    check("protect at confirm", {15'h0000, dev.wp_seen}, 16'h0001);
    WRITE_EN_I = 1'b1;
    cmd(8'h70);
    check("status during busy", {15'h0000, BUSY_O}, 16'h0001);
    cmd(8'h00);
    cmd(8'h70);
    op(KIND_RDATA, 16'h0000);
    check("status lane", got, 16'h00e0);
    check("strobes during busy", 16'(dev.bad), 16'h0000);
    WRITE_EN_I = 1'b1;
    cmd(8'h60);
    addr(8'h40);
    cmd(8'hd0);
    check("busy in erase", {15'h0000, BUSY_O}, 16'h0001);
    @(negedge CLK_I);
    WRITE_EN_I = 1'b0;
    repeat (6) @(negedge CLK_I);
    check("protect low", {15'h0000, PROTECT_N_O}, 16'h0000);
    check("abort", {15'h0000, BUSY_O}, 16'h0000);
    WRITE_EN_I = 1'b1;
    foreach (codes[i]) begin
      cmd(codes[i]);
      wait_for(1);
    end
    check("strobes during busy", 16'(dev.bad), 16'h0000);
    summarize();
  end
endmodule
